// ### src/efcr_top.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "efcr_map.svh"

module efcr_top
	import efcr_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire efcr_pins_s pins_in,
	input wire efcr_sense_s sense_in,
	output logic [7:0] rdata_out,
	output efcr_drive_s drive_out,
	output logic fuse_open_indicator_out,
	output logic fuse_open_indicator_oe_out
);

	efcr_state_s st_ff;
	efcr_state_s nxt_st;

	efcr_pins_s p;
	efcr_sense_s s;
	logic pdis_act;
	logic hr_allow;
	logic lr_allow;
	logic mon_kill;
	logic ss_rise;
	logic wr_ctrl;
	logic wr_stat0;
	logic wr_stat1;
	logic [7:0] ev0;
	logic [7:0] ev1;

	// Next state of the whole block
	always_comb begin
		nxt_st = st_ff;
		// Two-stage synchronisers, only the second stage is used
		nxt_st.pin1 = pins_in;
		nxt_st.pin2 = st_ff.pin1;
		nxt_st.sen1 = sense_in;
		nxt_st.sen2 = st_ff.sen1;
		p = st_ff.pin2;
		s = st_ff.sen2;

		wr_ctrl = wr_in && (addr_in == `EFCR_ADDR_CTRL);
		wr_stat0 = wr_in && (addr_in == `EFCR_ADDR_STAT0);
		wr_stat1 = wr_in && (addr_in == `EFCR_ADDR_STAT1);

		// Power disable acts always when gate pin low, else only with enable bit
		pdis_act = p.power_disable_pin &
			(p.power_disable_firmware_gate_pin ? st_ff.ctrl[`EFCR_CTRL_PDIS_EN] : 1'b1);
		hr_allow = p.high_rail_input_pin && !pdis_act && !s.hr_overtemp;
		lr_allow = p.low_rail_input_pin && !pdis_act && !s.lr_overtemp;

		// 12V fuse sequencing
		case (st_ff.hr_st)
			FS_OFF: begin
				if (hr_allow) begin
					nxt_st.hr_st = FS_LIVE;
				end
			end
			FS_LIVE: begin
				if (!hr_allow) begin
					nxt_st.hr_st = FS_OFF;
				end
			end
			default: begin
				nxt_st.hr_st = FS_OFF;
			end
		endcase

		// 5V fuse sequencing with reverse-current open state
		case (st_ff.lr_st)
			FS_OFF: begin
				if (lr_allow && !s.lr_reverse) begin
					nxt_st.lr_st = FS_LIVE;
				end
			end
			FS_LIVE: begin
				if (s.lr_reverse) begin
					nxt_st.lr_st = FS_OPEN;
				end else if (!lr_allow) begin
					nxt_st.lr_st = FS_OFF;
				end
			end
			FS_OPEN: begin
				if (!s.lr_reverse && lr_allow) begin
					nxt_st.lr_st = FS_LIVE;
				end
			end
			default: begin
				nxt_st.lr_st = FS_OFF;
			end
		endcase

		// Fault that takes down a fuse or regulator kills the monitors
		mon_kill = ((st_ff.hr_st == FS_LIVE) && !hr_allow) ||
			((st_ff.lr_st == FS_LIVE) && (!lr_allow || s.lr_reverse)) ||
			s.r33_undervolt || s.r33_overcurrent || s.core_overcurrent;

		// Status events; a clear write loses to a fresh event
		ev0 = {!p.high_rail_input_pin, !p.low_rail_input_pin, s.r33_undervolt, s.core_undervolt,
			s.hr_overtemp, s.lr_overtemp, s.hr_temp_warn, s.lr_temp_warn};
		ev1 = {s.hr_overcurrent, s.lr_overcurrent, s.r33_overcurrent, s.core_overcurrent,
			2'b00, s.high_rail_overvoltage_flag, s.low_rail_overvoltage_flag};
		if (wr_stat0 || (st_ff.stat0 == 8'h00)) begin
			nxt_st.stat0 = ev0;
		end
		if (wr_stat1 || (st_ff.stat1 == 8'h00)) begin
			nxt_st.stat1 = ev1;
		end

		// Voltage select registers
		if (wr_in && (addr_in == `EFCR_ADDR_CORE_SEL)) begin
			nxt_st.drv.core_voltage_select = wdata_in[5:0];
		end
		if (wr_in && (addr_in == `EFCR_ADDR_KEY)) begin
			nxt_st.drv.r33_select = wdata_in[4:0];
		end

		// Key: loaded by its own register, dropped by any other write
		if (wr_in) begin
			if (addr_in == `EFCR_ADDR_KEY) begin
				nxt_st.key = wdata_in[`EFCR_KEY_BIT];
			end else begin
				nxt_st.key = 1'b0;
			end
		end

		// Control register; core bits need the key
		if (wr_ctrl) begin
			nxt_st.ctrl[7:2] = wdata_in[7:2];
			if (st_ff.key) begin
				nxt_st.ctrl[1:0] = wdata_in[1:0];
			end
		end
		if (mon_kill) begin
			nxt_st.ctrl[`EFCR_CTRL_MON_EN] = 1'b0;
		end
		ss_rise = p.core_softstart_done && !st_ff.ss_prev;
		nxt_st.ss_prev = p.core_softstart_done;
		if (ss_rise) begin
			nxt_st.ctrl[`EFCR_CTRL_MON_DIS] = 1'b0;
		end
		if (!p.core_regulator_enable_pin) begin
			nxt_st.ctrl[1:0] = 2'b00;
		end

		// Drive outputs
		nxt_st.drv.hr_fuse_on = (nxt_st.hr_st == FS_LIVE);
		nxt_st.drv.lr_fuse_on = (nxt_st.lr_st == FS_LIVE);
		nxt_st.drv.hr_clamp = s.high_rail_overvoltage_flag;
		nxt_st.drv.lr_clamp = s.low_rail_overvoltage_flag;
		nxt_st.open_oe = (nxt_st.lr_st == FS_OPEN);

		// Reduced short-circuit limits
		if ((st_ff.hr_st == FS_LIVE) && s.hr_short) begin
			nxt_st.drv.hr_short_limit = 1'b1;
		end else if ((st_ff.stat0 == 8'h00) && (st_ff.stat1 == 8'h00) && !s.hr_short) begin
			nxt_st.drv.hr_short_limit = 1'b0;
		end
		if ((st_ff.lr_st == FS_LIVE) && s.lr_short) begin
			nxt_st.drv.lr_short_limit = 1'b1;
		end else if (p.r33_power_good && !s.lr_short) begin
			nxt_st.drv.lr_short_limit = 1'b0;
		end

		nxt_st.drv.hr_monitor_on = nxt_st.ctrl[`EFCR_CTRL_MON_EN];
		nxt_st.drv.lr_monitor_on = nxt_st.ctrl[`EFCR_CTRL_MON_EN];
		nxt_st.drv.monitor_gain = nxt_st.ctrl[`EFCR_CTRL_MON_GAIN];
		nxt_st.drv.core_pwm = nxt_st.ctrl[`EFCR_CTRL_CORE_PWM];
		nxt_st.drv.r33_pwm = nxt_st.ctrl[`EFCR_CTRL_R33_PWM];
		nxt_st.drv.deglitch_sel = nxt_st.ctrl[`EFCR_CTRL_DEGLITCH];

		// Core regulator on/off and power-good
		nxt_st.drv.core_on = p.core_regulator_enable_pin && !nxt_st.ctrl[`EFCR_CTRL_CORE_DIS];
		if (nxt_st.ctrl[`EFCR_CTRL_MON_DIS]) begin
			nxt_st.drv.core_power_good_pin = st_ff.drv.core_power_good_pin;
		end else begin
			nxt_st.drv.core_power_good_pin = nxt_st.drv.core_on && !s.core_undervolt;
		end
		nxt_st.drv.core_target_mv = `EFCR_CORE_BASE_MV +
			11'(nxt_st.drv.core_voltage_select) * `EFCR_CORE_STEP_MV;

		// Read data stands only in the cycle after the strobe
		nxt_st.rdata = 8'h00;
		if (rd_in) begin
			case (addr_in)
				`EFCR_ADDR_ID1: nxt_st.rdata = `EFCR_ID1_VALUE;
				`EFCR_ADDR_ID2: nxt_st.rdata = `EFCR_ID2_VALUE;
				`EFCR_ADDR_CORE_SEL: nxt_st.rdata = {2'b00, st_ff.drv.core_voltage_select};
				`EFCR_ADDR_KEY: nxt_st.rdata = {2'b00, st_ff.key, st_ff.drv.r33_select};
				`EFCR_ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
				`EFCR_ADDR_STAT0: nxt_st.rdata = st_ff.stat0;
				`EFCR_ADDR_STAT1: begin
					nxt_st.rdata = st_ff.stat1;
					nxt_st.rdata[`EFCR_STAT1_PDIS_STATE] = p.power_disable_pin;
				end
				default: nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff <= '0;
			st_ff.hr_st <= FS_OFF;
			st_ff.lr_st <= FS_OFF;
			st_ff.ctrl <= `EFCR_RST_CTRL;
			st_ff.drv.core_voltage_select <= `EFCR_RST_CORE_SEL;
			st_ff.drv.r33_select <= `EFCR_RST_R33_SEL;
			st_ff.drv.core_target_mv <= `EFCR_CORE_BASE_MV + 11'(`EFCR_RST_CORE_SEL) * `EFCR_CORE_STEP_MV;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register; indicator data is tied to 0
	assign rdata_out = st_ff.rdata;
	assign drive_out = st_ff.drv;
	assign fuse_open_indicator_out = 1'b0;
	assign fuse_open_indicator_oe_out = st_ff.open_oe;

endmodule : efcr_top

// ### include/efcr_map.svh
// Function
// - 12V fuse starts off; switches on input pin, power-disable pins, enable bit, faults.
// - 12V input over-voltage clamps the output and sets its status bit.
// - Clamped 12V fuse runs until over-temperature, restarts below hysteresis.
// - 12V reduced short limit stays until all latched status faults are cleared.
// - 5V input over-voltage clamps the output and sets its status bit.
// - 5V fuse shuts down at over-temperature, restarts below hysteresis.
// - Reverse current opens 5V fuse; restart when reverse gone and startup criteria met.
// - Open-drain indicator is active while the 5V fuse is in its open state.
// - 5V reduced short limit stays until 3.3V rail reports power good.
// - Both current monitors reset disabled; enabled only by a control bit.
// - Any fault turning off a fuse or regulator clears the single monitor enable bit.
// - A control bit selects one of two monitor gain settings.
// - Core power-good goes low when core output is over 10% low.
// - Core regulator follows its enable pin on and off.
// - Core enable pin low clears core disable and monitor-disable bits.
// - Core disable bits change by write only while the key bit is one.
// - Key bit clears on a write to any register other than 03H.
// - Monitor-disable set holds core power-good at its value when set.
// - Core disable bit set shuts the core off; clear follows the enable pin.
// - Clearing disable restarts core; soft-start end rising edge clears monitor-disable.
// - Core select code 0 means 0.770 V, each step adds 5 mV.
// - Core select resets to 100010, giving 0.94 V.
// - Status registers latch first fault, hold it; host clears by writing them.
`ifndef EFCR_MAP_SVH
`define EFCR_MAP_SVH

// Register offsets
`define EFCR_ADDR_ID1 8'h00
`define EFCR_ADDR_ID2 8'h01
`define EFCR_ADDR_CORE_SEL 8'h02
`define EFCR_ADDR_KEY 8'h03
`define EFCR_ADDR_CTRL 8'h04
`define EFCR_ADDR_STAT0 8'h05
`define EFCR_ADDR_STAT1 8'h06

// Control, key and status register bit positions
`define EFCR_CTRL_PDIS_EN 7
`define EFCR_CTRL_MON_GAIN 6
`define EFCR_CTRL_R33_PWM 5
`define EFCR_CTRL_CORE_PWM 4
`define EFCR_CTRL_DEGLITCH 3
`define EFCR_CTRL_MON_EN 2
`define EFCR_CTRL_MON_DIS 1
`define EFCR_CTRL_CORE_DIS 0
`define EFCR_KEY_BIT 5
`define EFCR_STAT1_PDIS_STATE 3

// Reset values
`define EFCR_RST_CORE_SEL 6'h22
`define EFCR_RST_R33_SEL 5'h13
`define EFCR_RST_CTRL 8'h00

// Identity values, arbitrary
`define EFCR_ID1_VALUE 8'hA5
`define EFCR_ID2_VALUE 8'h5A

// Core target voltage encoding in millivolts
`define EFCR_CORE_BASE_MV 11'd770
`define EFCR_CORE_STEP_MV 11'd5

`endif

// ### include/efcr_pkg.sv
package efcr_pkg;

	// Fuse state, one-hot
	typedef enum logic [2:0] {
		FS_OFF = 3'b001,
		FS_LIVE = 3'b010,
		FS_OPEN = 3'b100
	} efcr_fuse_e;

	// Pin level inputs
	typedef struct packed {
		logic high_rail_input_pin;
		logic low_rail_input_pin;
		logic power_disable_pin;
		logic power_disable_firmware_gate_pin;
		logic core_regulator_enable_pin;
		logic core_softstart_done;
		logic r33_power_good;
	} efcr_pins_s;

	// Analog comparator flags
	typedef struct packed {
		logic high_rail_overvoltage_flag;
		logic low_rail_overvoltage_flag;
		logic hr_overtemp;
		logic lr_overtemp;
		logic hr_temp_warn;
		logic lr_temp_warn;
		logic hr_short;
		logic lr_short;
		logic hr_overcurrent;
		logic lr_overcurrent;
		logic lr_reverse;
		logic r33_undervolt;
		logic r33_overcurrent;
		logic core_undervolt;
		logic core_overcurrent;
	} efcr_sense_s;

	// Drive toward the analog blocks and pins
	typedef struct packed {
		logic hr_fuse_on;
		logic lr_fuse_on;
		logic hr_clamp;
		logic lr_clamp;
		logic hr_short_limit;
		logic lr_short_limit;
		logic hr_monitor_on;
		logic lr_monitor_on;
		logic monitor_gain;
		logic core_on;
		logic core_pwm;
		logic r33_pwm;
		logic deglitch_sel;
		logic core_power_good_pin;
		logic [5:0] core_voltage_select;
		logic [10:0] core_target_mv;
		logic [4:0] r33_select;
	} efcr_drive_s;

	// Whole block state
	typedef struct packed {
		efcr_pins_s pin1;
		efcr_pins_s pin2;
		efcr_sense_s sen1;
		efcr_sense_s sen2;
		logic ss_prev;
		efcr_fuse_e hr_st;
		efcr_fuse_e lr_st;
		logic key;
		logic [7:0] ctrl;
		logic [7:0] stat0;
		logic [7:0] stat1;
		logic [7:0] rdata;
		logic open_oe;
		efcr_drive_s drv;
	} efcr_state_s;

endpackage : efcr_pkg

// ### tb/efcr_top_props.sv
`timescale 1ns/1ns
module efcr_top_props
	import efcr_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire efcr_pins_s pins_in,
	input wire efcr_sense_s sense_in,
	input wire efcr_drive_s drive_out,
	input wire logic fuse_open_indicator_out,
	input wire logic fuse_open_indicator_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Leaving reset: 12V fuse and 5V monitor off, default core code
	a_reset_state: assert property ($fell(rst_in) |-> drive_out.core_voltage_select == 6'h22
		&& !drive_out.hr_fuse_on && !drive_out.lr_monitor_on) else $error("reset state wrong");
	a_target_code: assert property (drive_out.core_target_mv ==
		11'd770 + 11'd5 * {5'h00, drive_out.core_voltage_select}) else $error("core target wrong");
	// Synced flags act within three edges
	a_hr_clamp: assert property (sense_in.high_rail_overvoltage_flag [*3] |=> drive_out.hr_clamp)
		else $error("12V clamp missing");
	a_lr_clamp: assert property (sense_in.low_rail_overvoltage_flag [*3] |=> drive_out.lr_clamp)
		else $error("5V clamp missing");
	a_hr_overtemp: assert property (sense_in.hr_overtemp [*3] |=> !drive_out.hr_fuse_on)
		else $error("12V fuse on while hot");
	a_reverse_open: assert property (sense_in.lr_reverse [*3] |=>
		!drive_out.lr_fuse_on && !drive_out.lr_monitor_on) else $error("5V fuse not opened");
	a_open_drive: assert property (drive_out.lr_fuse_on && sense_in.lr_reverse ##1 sense_in.lr_reverse [*3] |=>
		fuse_open_indicator_oe_out && !fuse_open_indicator_out) else $error("open indicator idle");
	a_core_pin_low: assert property (!pins_in.core_regulator_enable_pin [*3] |=> !drive_out.core_on)
		else $error("core on with pin low");
	// Main scenarios
	c_open: cover property (fuse_open_indicator_oe_out);
	c_clamp: cover property (drive_out.hr_clamp && drive_out.lr_clamp);
	c_core_off: cover property ($fell(drive_out.core_on));
endmodule : efcr_top_props

bind efcr_top efcr_top_props efcr_top_props_inst (.clk_in(clk_in), .rst_in(rst_in), .pins_in(pins_in),
	.sense_in(sense_in), .drive_out(drive_out), .fuse_open_indicator_out(fuse_open_indicator_out),
	.fuse_open_indicator_oe_out(fuse_open_indicator_oe_out));

// ### tb/efcr_sys_model.sv
`timescale 1ns/1ns
module efcr_sys_model
	import efcr_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire efcr_drive_s drive_in,
	input wire logic od_data_in,
	input wire logic od_oe_in,
	output logic ss_done_out,
	output logic core_uv_out,
	output logic r33_pg_out,
	output logic od_wire_out
);
	logic [7:0] ss_ff;
	// Pulled-up indicator line, low only while sunk
	assign od_wire_out = od_oe_in ? od_data_in : 1'b1;
	// Rails follow their switches
	assign core_uv_out = !drive_in.core_on;
	assign r33_pg_out = drive_in.lr_fuse_on;
	assign ss_done_out = ss_ff[7];
	// Soft start ends eight cycles after core turn-on
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ss_ff <= 8'h00;
		end else begin
			ss_ff <= drive_in.core_on ? {ss_ff[6:0], 1'b1} : 8'h00;
		end
	end
endmodule : efcr_sys_model

// ### tb/tb_efcr_top.sv
`timescale 1ns/1ns
module tb_efcr_top
	import efcr_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [4:0] pin_b = 5'h00;
	logic [14:0] sen = 15'h0000;
	logic [7:0] rdata_out;
	efcr_drive_s drive_out;
	logic od_data, od_oe, od_wire, ss_done, r33_pg, core_uv;
	int failures = 0;
	int comparisons = 0;
	// System clock
	always #50 clk_in = ~clk_in;
	efcr_top efcr_top_inst (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .pins_in(efcr_pins_s'({pin_b, ss_done, r33_pg})),
		.sense_in(efcr_sense_s'({sen[14:2], core_uv | sen[1], sen[0]})), .rdata_out(rdata_out), .drive_out(drive_out),
		.fuse_open_indicator_out(od_data), .fuse_open_indicator_oe_out(od_oe));
	efcr_sys_model efcr_sys_model_inst (.clk_in(clk_in), .rst_in(rst_in), .drive_in(drive_out), .od_data_in(od_data),
		.od_oe_in(od_oe), .ss_done_out(ss_done), .core_uv_out(core_uv), .r33_pg_out(r33_pg), .od_wire_out(od_wire));
	// Compare and count
	task ck(input string n, input logic [10:0] s, input logic [10:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : ck
	task fl(input string n, input logic s, input logic e);
		ck(n, {10'h000, s}, {10'h000, e});
	endtask : fl
	// Register bus cycles
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		ck("rdata", {3'h0, rdata_out}, {3'h0, e});
	endtask : rd
	// Let changes pass the synchronisers
	task st(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask : st
	task sb(input int i, input logic v);
		@(posedge clk_in);
		sen[i] <= v;
		st(5);
	endtask : sb
	task pn(input logic [4:0] v);
		@(posedge clk_in);
		pin_b <= v;
		st(20);
	endtask : pn
	task test_done;
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		test_done();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
		ck("mv", drive_out.core_target_mv, 11'd940);
		fl("fuse12", drive_out.hr_fuse_on, 1'b0);
		rd(8'h02, 8'h22);
		rd(8'h04, 8'h00);
		wr(8'h02, 8'h3F);
		st(1);
		ck("mv", drive_out.core_target_mv, 11'd1085);
		pn(5'b11001);
		fl("fuse12", drive_out.hr_fuse_on, 1'b1);
		fl("core", drive_out.core_on, 1'b1);
		wr(8'h04, 8'h03);
		rd(8'h04, 8'h00);
		wr(8'h03, 8'h33);
		rd(8'h03, 8'h33);
		wr(8'h04, 8'h03);
		rd(8'h03, 8'h13);
		st(3);
		fl("core", drive_out.core_on, 1'b0);
		fl("pg", drive_out.core_power_good_pin, 1'b1);
		wr(8'h03, 8'h33);
		wr(8'h04, 8'h02);
		st(20);
		fl("core", drive_out.core_on, 1'b1);
		rd(8'h04, 8'h00);
		wr(8'h03, 8'h33);
		wr(8'h04, 8'h03);
		pn(5'b11000);
		rd(8'h04, 8'h00);
		pn(5'b11001);
		wr(8'h04, 8'h44);
		st(2);
		fl("gain", drive_out.monitor_gain, 1'b1);
		fl("mon12", drive_out.hr_monitor_on, 1'b1);
		sb(4, 1'b1);
		fl("ind", od_wire, 1'b0);
		rd(8'h04, 8'h40);
		sb(4, 1'b0);
		fl("fuse5", drive_out.lr_fuse_on, 1'b1);
		wr(8'h05, 8'h00);
		wr(8'h06, 8'h00);
		sb(14, 1'b1);
		rd(8'h06, 8'h02);
		sb(13, 1'b1);
		sb(8, 1'b1);
		sb(8, 1'b0);
		fl("lim12", drive_out.hr_short_limit, 1'b1);
		rd(8'h06, 8'h02);
		sb(14, 1'b0);
		wr(8'h06, 8'h00);
		rd(8'h06, 8'h01);
		sb(13, 1'b0);
		wr(8'h05, 8'h00);
		wr(8'h06, 8'h00);
		st(2);
		fl("lim12", drive_out.hr_short_limit, 1'b0);
		sb(12, 1'b1);
		rd(8'h05, 8'h08);
		sb(12, 1'b0);
		fl("fuse12", drive_out.hr_fuse_on, 1'b1);
		// Power disable pin with gate low, then gated by the enable bit
		pn(5'b11101);
		fl("fuse12", drive_out.hr_fuse_on, 1'b0);
		rd(8'h06, 8'h08);
		pn(5'b11111);
		fl("fuse12", drive_out.hr_fuse_on, 1'b1);
		wr(8'h04, 8'h80);
		st(2);
		fl("fuse12", drive_out.hr_fuse_on, 1'b0);
		pn(5'b11001);
		// 5V short limit held while the 3.3V rail is down
		sb(7, 1'b1);
		sb(11, 1'b1);
		fl("fuse5", drive_out.lr_fuse_on, 1'b0);
		sb(7, 1'b0);
		fl("lim5", drive_out.lr_short_limit, 1'b1);
		sb(11, 1'b0);
		fl("fuse5", drive_out.lr_fuse_on, 1'b1);
		st(2);
		fl("lim5", drive_out.lr_short_limit, 1'b0);
		// Core output under target pulls power-good low
		sb(1, 1'b1);
		fl("pg", drive_out.core_power_good_pin, 1'b0);
		sb(1, 1'b0);
		fl("pg", drive_out.core_power_good_pin, 1'b1);
		test_done();
	end
endmodule : tb_efcr_top
